// *** gp_map.svh ***
// Constants of the IEEE-488 talker and listener port.
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

// ************************************************************
// Addressing
// ************************************************************
`define GP_MAX_ADDR  5'h1e
`define GP_LAG_BASE  7'h20
`define GP_TAG_BASE  7'h40
`define GP_SEC_BASE  7'h60
`define GP_GRP_MASK  7'h60

// ************************************************************
// Interface command codes
// ************************************************************
`define GP_CMD_GTL   7'h01
`define GP_CMD_SDC   7'h04
`define GP_CMD_GET   7'h08
`define GP_CMD_LLO   7'h11
`define GP_CMD_DCL   7'h14
`define GP_CMD_SPE   7'h18
`define GP_CMD_SPD   7'h19
`define GP_CMD_UNL   7'h3f
`define GP_CMD_UNT   7'h5f

// ************************************************************
// Layout and sizes
// ************************************************************
`define GP_RSV_BIT   6
`define GP_IN_W      15
`define GP_RX_W      9

`endif

// *** gp_pkg.sv ***
// Types of the IEEE-488 talker and listener port.
package gp_pkg;

  // Acceptor handshake states.
  typedef enum logic [1:0] {
    GP_AH_READY,
    GP_AH_ACCEPT,
    GP_AH_WAITEND
  } gp_ah_t;

  // Source handshake states.
  typedef enum logic [1:0] {
    GP_SH_IDLE,
    GP_SH_SETUP,
    GP_SH_VALID
  } gp_sh_t;

  // Whole state of the port.
  typedef struct packed {
    gp_ah_t     ah;
    gp_sh_t     sh;
    logic [7:0] rx_byte;
    logic       rx_eoi;
    logic       rx_atn;
    logic [7:0] tx_byte;
    logic       tx_eoi;
    logic       tx_stb;
    logic       listener;
    logic       talker;
    logic       spoll;
    logic       remote;
    logic       lockout;
    logic       panel_lock;
    logic       srq;
    logic       dev_clear;
    logic       trigger;
    logic       tx_take;
    logic [7:0] dio_n;
    logic       dio_oe;
    logic       eoi_n;
    logic       eoi_oe;
    logic       dav_n;
    logic       dav_oe;
    logic       nrfd_n;
    logic       nrfd_oe;
    logic       ndac_n;
    logic       ndac_oe;
    logic       srq_n;
    logic       srq_oe;
  } gp_st_t;

endpackage

// *** gp_sync.sv ***
// Two-stage synchroniser for the bus input lines.
module gp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // Lines in and out.
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gp_sync_t;

  gp_sync_t st_r;
  gp_sync_t st_nxt;

  // The first stage feeds only the second one.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end

  // Released bus lines sit high, so reset to all ones.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.s2;

endmodule // gp_sync

// *** gp_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
module gp_buf2 #(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // Filling side.
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  // Draining side.
  output logic      [W-1:0] o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);

  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic         v0;
    logic         v1;
  } gp_buf_t;

  gp_buf_t st_r;
  gp_buf_t st_nxt;

  // Head entry drains, second entry refills the head.
  always_comb begin
    st_nxt = st_r;
    if (st_r.v0 && i_ready) begin
      st_nxt.d0 = st_r.d1;
      st_nxt.v0 = st_r.v1;
      st_nxt.v1 = 1'b0;
    end
    if (i_valid && !st_r.v1) begin
      if (!st_nxt.v0) begin
        st_nxt.d0 = i_data;
        st_nxt.v0 = 1'b1;
      end else begin
        st_nxt.d1 = i_data;
        st_nxt.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Full only when both entries hold words.
  assign o_ready = !st_r.v1;
  assign o_data  = st_r.d0;
  assign o_valid = st_r.v0;

endmodule // gp_buf2

// *** gp_port.sv ***
// IEEE-488 talker and listener port of the instrument.
// How it works
// - Bytes move in parallel on eight data lines, bit 0 on DIO1.
// - Every bus line is active low; driven low means true.
// - A local primary address from 0 to 30 is used for matching.
// - Own listen byte, address ORed with 20h under ATN, makes a listener.
// - Own talk byte, address ORed with 40h under ATN, makes the talker.
// - Secondary bytes 60h to 7Fh never change the addressed state.
// - The port listens and talks, one byte per handshake cycle.
// - ATN bytes are commands; other bytes go to the parser if listening.
// - IFC at once returns talker and listener to idle.
// - Remote is entered when REN is true and the port is addressed to listen.
// - EOI marks the last byte of a message both ways.
// - SRQ is driven while service is wanted, until polled.
// - DAV is driven only by the talker, after data is stable.
// - Listener holds NRFD while busy; talker waits for NRFD release.
// - Listener holds NDAC until byte latched; talker holds DAV meanwhile.
// - The three lines interlock fully for data, addresses and commands.
// - Local lockout disables the front panel while remote.
// - Device clear, or selective clear when listening, restores defaults.
// - Go-to-local when listening leaves remote mode.
// - Trigger when listening starts a new reading.
// - Unlisten and untalk idle the roles whatever the address.
// - Commands decode as 01,04,08,11,14,18,19,3F,5F hex.
// - Serial poll enable makes a talker send the status byte.
`include "gp_map.svh"
module gp_port (
  // Clock and reset.
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  // Local configuration.
  input  wire logic [4:0] i_pri_addr,
  // Bus lines at the pins, active low.
  input  wire logic [7:0] i_dio_n,
  input  wire logic       i_atn_n,
  input  wire logic       i_ifc_n,
  input  wire logic       i_ren_n,
  input  wire logic       i_eoi_n,
  input  wire logic       i_dav_n,
  input  wire logic       i_nrfd_n,
  input  wire logic       i_ndac_n,
  // Bus drivers, each with its output enable.
  output logic      [7:0] o_dio_n,
  output logic            o_dio_oe,
  output logic            o_eoi_n,
  output logic            o_eoi_oe,
  output logic            o_dav_n,
  output logic            o_dav_oe,
  output logic            o_nrfd_n,
  output logic            o_nrfd_oe,
  output logic            o_ndac_n,
  output logic            o_ndac_oe,
  output logic            o_srq_n,
  output logic            o_srq_oe,
  // Received data toward the parser.
  output logic      [7:0] o_rx_data,
  output logic            o_rx_end,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  // Response data from the instrument.
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_end,
  input  wire logic       i_tx_valid,
  output logic            o_tx_take,
  // Service request and status.
  input  wire logic       i_srq_req,
  input  wire logic [7:0] i_stb,
  // Interface state.
  output logic            o_listener,
  output logic            o_talker,
  output logic            o_remote,
  output logic            o_panel_lock,
  output logic            o_spoll,
  output logic            o_dev_clear,
  output logic            o_trigger
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // Own address byte of a group; address 31 never matches.
  function automatic logic own_cmd(input logic [6:0] cmd, input logic [6:0] base,
                                   input logic [4:0] addr);
    own_cmd = (addr <= `GP_MAX_ADDR) && (cmd == (base | {2'h0, addr}));
  endfunction

  // Byte belongs to a command group.
  function automatic logic in_grp(input logic [6:0] cmd, input logic [6:0] base);
    in_grp = (cmd & `GP_GRP_MASK) == base;
  endfunction

  // ************************************************************
  // Input synchronisation
  // ************************************************************

  logic [`GP_IN_W-1:0] bus_n;
  logic [7:0]          dio_t;
  logic                atn_t;
  logic                ifc_t;
  logic                ren_t;
  logic                eoi_t;
  logic                dav_t;
  logic                nrfd_t;
  logic                ndac_t;

  gp_sync #(
    .W (`GP_IN_W)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_d        ({i_dio_n, i_atn_n, i_ifc_n, i_ren_n, i_eoi_n, i_dav_n,
                  i_nrfd_n, i_ndac_n}),
    .o_q        (bus_n)
  );

  // Low on a line reads as true; DIO1 lands in bit 0.
  assign {dio_t, atn_t, ifc_t, ren_t, eoi_t, dav_t, nrfd_t, ndac_t} = ~bus_n;

  // ************************************************************
  // Receive buffer
  // ************************************************************

  logic           push;
  logic           buf_rdy;
  gp_pkg::gp_st_t st_r;
  gp_pkg::gp_st_t st_nxt;

  gp_buf2 #(
    .W (`GP_RX_W)
  ) u_rxbuf (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_data     ({st_r.rx_eoi, st_r.rx_byte}),
    .i_valid    (push),
    .o_ready    (buf_rdy),
    .o_data     ({o_rx_end, o_rx_data}),
    .o_valid    (o_rx_valid),
    .i_ready    (i_rx_ready)
  );

  // ************************************************************
  // Port state
  // ************************************************************

  logic [6:0]     cmd;
  logic           part;
  logic           drive;

  // Handshakes, command decode and line drivers.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.dev_clear = 1'b0;
    st_nxt.trigger   = 1'b0;
    st_nxt.tx_take   = 1'b0;
    push             = 1'b0;
    cmd              = st_r.rx_byte[6:0];
    // Acceptor: every device takes ATN bytes, data only when listening.
    case (st_r.ah)
      gp_pkg::GP_AH_READY: begin
        if ((atn_t || st_r.listener) && dav_t && !st_r.nrfd_oe) begin
          st_nxt.rx_byte = dio_t;
          st_nxt.rx_eoi  = eoi_t;
          st_nxt.rx_atn  = atn_t;
          st_nxt.ah      = gp_pkg::GP_AH_ACCEPT;
        end
      end
      gp_pkg::GP_AH_ACCEPT: begin
        if (st_r.rx_atn) begin
          st_nxt.ah = gp_pkg::GP_AH_WAITEND;
          if (own_cmd(cmd, `GP_LAG_BASE, i_pri_addr)) begin
            st_nxt.listener = 1'b1;
            if (ren_t) begin
              st_nxt.remote = 1'b1;
            end
          end else if (cmd == `GP_CMD_UNL) begin
            st_nxt.listener = 1'b0;
          end else if (own_cmd(cmd, `GP_TAG_BASE, i_pri_addr)) begin
            st_nxt.talker = 1'b1;
          end else if (in_grp(cmd, `GP_TAG_BASE)) begin
            st_nxt.talker = 1'b0;
          end else if (in_grp(cmd, `GP_SEC_BASE)) begin
            st_nxt.talker = st_r.talker;
          end else if (cmd == `GP_CMD_LLO) begin
            st_nxt.lockout = 1'b1;
          end else if (cmd == `GP_CMD_DCL ||
                       (cmd == `GP_CMD_SDC && st_r.listener)) begin
            st_nxt.dev_clear = 1'b1;
          end else if (cmd == `GP_CMD_GTL && st_r.listener) begin
            st_nxt.remote = 1'b0;
          end else if (cmd == `GP_CMD_GET && st_r.listener) begin
            st_nxt.trigger = 1'b1;
          end else if (cmd == `GP_CMD_SPE) begin
            st_nxt.spoll = 1'b1;
          end else if (cmd == `GP_CMD_SPD) begin
            st_nxt.spoll = 1'b0;
          end
        end else if (!st_r.listener) begin
          st_nxt.ah = gp_pkg::GP_AH_WAITEND;
        end else if (buf_rdy) begin
          push      = 1'b1;
          st_nxt.ah = gp_pkg::GP_AH_WAITEND;
        end
      end
      gp_pkg::GP_AH_WAITEND: begin
        if (!dav_t) begin
          st_nxt.ah = gp_pkg::GP_AH_READY;
        end
      end
      default: begin
        st_nxt.ah = gp_pkg::GP_AH_READY;
      end
    endcase
    // Remote and lockout fall away with REN.
    if (!ren_t) begin
      st_nxt.remote  = 1'b0;
      st_nxt.lockout = 1'b0;
    end
    // Interface clear idles both roles at once.
    if (ifc_t) begin
      st_nxt.listener = 1'b0;
      st_nxt.talker   = 1'b0;
      st_nxt.spoll    = 1'b0;
    end
    st_nxt.panel_lock = st_nxt.lockout && st_nxt.remote;
    // Source: status byte in serial poll, else response data.
    case (st_r.sh)
      gp_pkg::GP_SH_IDLE: begin
        if (st_nxt.talker && !atn_t && !nrfd_t) begin
          if (st_nxt.spoll) begin
            st_nxt.tx_byte = i_stb;
            st_nxt.tx_byte[`GP_RSV_BIT] = st_r.srq;
            st_nxt.tx_eoi  = 1'b0;
            st_nxt.tx_stb  = 1'b1;
            st_nxt.sh      = gp_pkg::GP_SH_SETUP;
          end else if (i_tx_valid) begin
            st_nxt.tx_byte = i_tx_data;
            st_nxt.tx_eoi  = i_tx_end;
            st_nxt.tx_stb  = 1'b0;
            st_nxt.sh      = gp_pkg::GP_SH_SETUP;
          end
        end
      end
      gp_pkg::GP_SH_SETUP: begin
        if (!nrfd_t && ndac_t) begin
          st_nxt.sh = gp_pkg::GP_SH_VALID;
        end
      end
      gp_pkg::GP_SH_VALID: begin
        if (!ndac_t) begin
          st_nxt.sh = gp_pkg::GP_SH_IDLE;
          if (st_r.tx_stb) begin
            if (st_r.tx_byte[`GP_RSV_BIT]) begin
              st_nxt.srq = 1'b0;
            end
          end else begin
            st_nxt.tx_take = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.sh = gp_pkg::GP_SH_IDLE;
      end
    endcase
    // ATN or loss of talker status ends any byte in flight.
    if (atn_t || !st_nxt.talker) begin
      st_nxt.sh = gp_pkg::GP_SH_IDLE;
    end
    // A new request wins over a clear in the same cycle.
    if (i_srq_req) begin
      st_nxt.srq = 1'b1;
    end
    // Line drivers follow the next state.
    part            = atn_t || st_nxt.listener;
    drive           = st_nxt.sh != gp_pkg::GP_SH_IDLE;
    st_nxt.nrfd_oe  = part && (st_nxt.ah != gp_pkg::GP_AH_READY ||
                               (!atn_t && !buf_rdy));
    st_nxt.ndac_oe  = part && st_nxt.ah != gp_pkg::GP_AH_WAITEND;
    st_nxt.nrfd_n   = !st_nxt.nrfd_oe;
    st_nxt.ndac_n   = !st_nxt.ndac_oe;
    st_nxt.dio_oe   = drive;
    st_nxt.dio_n    = ~st_nxt.tx_byte;
    st_nxt.eoi_oe   = drive;
    st_nxt.eoi_n    = !st_nxt.tx_eoi;
    st_nxt.dav_oe   = drive;
    st_nxt.dav_n    = st_nxt.sh != gp_pkg::GP_SH_VALID;
    st_nxt.srq_oe   = st_nxt.srq;
    st_nxt.srq_n    = !st_nxt.srq;
  end

  // All port state in one register; drive levels are don't-care with enables low.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Every output except o_rx_data, o_rx_end and o_rx_valid comes from the state register.
  assign o_dio_n      = st_r.dio_n;
  assign o_dio_oe     = st_r.dio_oe;
  assign o_eoi_n      = st_r.eoi_n;
  assign o_eoi_oe     = st_r.eoi_oe;
  assign o_dav_n      = st_r.dav_n;
  assign o_dav_oe     = st_r.dav_oe;
  assign o_nrfd_n     = st_r.nrfd_n;
  assign o_nrfd_oe    = st_r.nrfd_oe;
  assign o_ndac_n     = st_r.ndac_n;
  assign o_ndac_oe    = st_r.ndac_oe;
  assign o_srq_n      = st_r.srq_n;
  assign o_srq_oe     = st_r.srq_oe;
  assign o_tx_take    = st_r.tx_take;
  assign o_listener   = st_r.listener;
  assign o_talker     = st_r.talker;
  assign o_remote     = st_r.remote;
  assign o_panel_lock = st_r.panel_lock;
  assign o_spoll      = st_r.spoll;
  assign o_dev_clear  = st_r.dev_clear;
  assign o_trigger    = st_r.trigger;

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  logic acc_cmd;
  assign acc_cmd = st_r.ah == gp_pkg::GP_AH_ACCEPT && st_r.rx_atn && !ifc_t;

  // DAV is asserted only after all listeners released NRFD.
  a_dav_waits_rdy: assert property ($fell(o_dav_n) |-> $past(!nrfd_t))
    else $error("DAV asserted while NRFD was held.");
  // DAV stays asserted until NDAC is released.
  a_dav_holds_acc: assert property (o_dav_oe && !o_dav_n && ndac_t && !atn_t && !ifc_t
                                    |=> !o_dav_n)
    else $error("DAV released before NDAC release.");
  // Data does not move while DAV is asserted.
  a_data_stable: assert property (o_dav_oe && !o_dav_n |-> $stable(o_dio_n) && o_dio_oe)
    else $error("Data lines changed under DAV.");
  // A response word is consumed only after acceptance.
  a_take_after_acc: assert property (o_tx_take |-> $past(!ndac_t) && $past(!o_dav_n))
    else $error("Word taken before NDAC release.");
  // IFC idles both roles on the next edge.
  a_ifc_idles: assert property (ifc_t |=> !o_talker && !o_listener)
    else $error("Role survived IFC.");
  // Own listen byte makes a listener.
  a_own_listen: assert property (acc_cmd && i_pri_addr <= `GP_MAX_ADDR &&
    st_r.rx_byte[6:0] == (`GP_LAG_BASE | {2'h0, i_pri_addr}) |=> o_listener)
    else $error("Own listen byte ignored.");
  // Own talk byte makes the talker.
  a_own_talk: assert property (acc_cmd && i_pri_addr <= `GP_MAX_ADDR &&
    st_r.rx_byte[6:0] == (`GP_TAG_BASE | {2'h0, i_pri_addr}) |=> o_talker)
    else $error("Own talk byte ignored.");
  // Secondary bytes leave the roles alone.
  a_sec_ignored: assert property (acc_cmd && st_r.rx_byte[6:5] == 2'h3
                                  |=> $stable(o_talker) && $stable(o_listener))
    else $error("Secondary byte changed addressing.");
  // Unlisten idles the listener.
  a_unl_idles: assert property (acc_cmd && st_r.rx_byte[6:0] == `GP_CMD_UNL
                                |=> !o_listener)
    else $error("Listener survived unlisten.");
  // A latched command byte holds NRFD and NDAC.
  a_busy_holds: assert property (acc_cmd |-> o_nrfd_oe && o_ndac_oe)
    else $error("Handshake released during command processing.");
  // A service request drives SRQ on the next edge.
  a_srq_drives: assert property (i_srq_req |=> o_srq_oe && !o_srq_n)
    else $error("SRQ not driven after request.");

  c_rx_word: cover property (push ##[1:20] o_rx_valid);
  c_tx_word: cover property (o_tx_take);
  c_spoll_read: cover property (o_spoll && o_srq_oe ##[1:200] !o_srq_oe);

endmodule // gp_port

// *** gp_ctl_model.sv ***
// Behavioural IEEE-488 bus controller that talks and listens.
module gp_ctl_model (
  // Clock.
  input  wire logic       i_core_clk,
  // Wired bus levels.
  input  wire logic [7:0] i_dio_w,
  input  wire logic       i_eoi_w,
  input  wire logic       i_dav_w,
  input  wire logic       i_nrfd_w,
  input  wire logic       i_ndac_w,
  // Controller drivers, active low.
  output logic      [7:0] o_dio_n,
  output logic            o_eoi_n,
  output logic            o_dav_n,
  output logic            o_nrfd_n,
  output logic            o_ndac_n,
  output logic            o_atn_n,
  output logic            o_ifc_n,
  output logic            o_ren_n
);
  int n_to;
  int slow;
  // Lines released, acceptor not ready.
  initial begin
    {o_dio_n, o_eoi_n, o_dav_n, o_atn_n, o_ifc_n, o_ren_n} = 13'h1fff;
    {o_nrfd_n, o_ndac_n} = 2'h0;
    n_to = 0;
    slow = 0;
  end
  function automatic logic pick(input int sel);
    return (sel == 0) ? i_nrfd_w : (sel == 1) ? i_ndac_w : i_dav_w;
  endfunction
  // Bounded wait for a wired line; a hang is counted.
  task automatic wt(input int sel, input logic v);
    int k;
    k = 0;
    while (pick(sel) !== v && k < 500) begin
      @(negedge i_core_clk);
      k++;
    end
    if (k == 500) n_to++;
  endtask
  // Sets attention and lets it settle before any byte.
  task automatic set_atn(input logic atn);
    if (o_atn_n !== !atn) begin
      o_atn_n = !atn;
      repeat (4) @(negedge i_core_clk);
    end
  endtask
  // One byte as source.
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    @(negedge i_core_clk);
    {o_nrfd_n, o_ndac_n} = 2'h3;
    set_atn(atn);
    wt(0, 1'b1);
    o_dio_n = ~b;
    o_eoi_n = !eoi;
    @(negedge i_core_clk);
    o_dav_n = 1'b0;
    wt(1, 1'b1);
    {o_dav_n, o_eoi_n, o_dio_n} = 10'h3ff;
    {o_nrfd_n, o_ndac_n} = 2'h0;
  endtask
  // One byte as acceptor, optionally slow to get ready.
  task automatic recv(output logic [7:0] b, output logic e);
    @(negedge i_core_clk);
    set_atn(1'b0);
    repeat (slow) @(negedge i_core_clk);
    o_nrfd_n = 1'b1;
    wt(2, 1'b0);
    b = ~i_dio_w;
    e = !i_eoi_w;
    @(negedge i_core_clk);
    {o_nrfd_n, o_ndac_n} = 2'h1;
    wt(2, 1'b1);
    o_ndac_n = 1'b0;
  endtask
endmodule // gp_ctl_model

// *** test_gp_port.sv ***
// Self-checking bench of the IEEE-488 talker and listener port.
`include "gp_map.svh"
module test_gp_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, resetn = 1'b0, rx_ready = 1'b0, stall = 1'b1;
  logic       tx_end = 1'b0, tx_valid = 1'b0, srq_req = 1'b0, e;
  logic [7:0] tx_data = 8'h00, stb = 8'h00, b, d, dio_n, c_dio, w_dio, rx_data;
  logic [4:0] a = 5'h00;
  logic [3:0] n_trig = 4'h0, n_clr = 4'h0;
  logic       dio_oe, eoi_n, eoi_oe, dav_n, dav_oe, nrfd_n, nrfd_oe, ndac_n, ndac_oe;
  logic       srq_n, srq_oe, rx_end, rx_valid, tx_take, listener, talker, remote;
  logic       panel_lock, spoll, dev_clear, trigger, c_eoi, c_dav, c_nrfd, c_ndac;
  logic       atn_n, ifc_n, ren_n, w_eoi, w_dav, w_nrfd, w_ndac, w_srq;
  logic [8:0] q[$], txq[$], exq[$];
  logic [6:0] cmd [5] = '{`GP_CMD_LLO, `GP_CMD_GET, `GP_CMD_SDC, `GP_CMD_DCL, `GP_CMD_GTL};
  logic [9:0] cex [5] = '{10'h003, 10'h043, 10'h047, 10'h04b, 10'h048};
  int         n_fail = 0, num_checks = 0, i;
  // Wired-AND bus with pull-ups.
  assign w_dio  = c_dio & (dio_oe ? dio_n : 8'hff);
  assign w_eoi  = c_eoi & (eoi_oe ? eoi_n : 1'b1);
  assign w_dav  = c_dav & (dav_oe ? dav_n : 1'b1);
  assign w_nrfd = c_nrfd & (nrfd_oe ? nrfd_n : 1'b1);
  assign w_ndac = c_ndac & (ndac_oe ? ndac_n : 1'b1);
  assign w_srq  = srq_oe ? srq_n : 1'b1;
  always #2.5 clk = ~clk;
  gp_port u_gp_port (.i_core_clk(clk), .i_resetn(resetn), .i_pri_addr(a), .i_dio_n(w_dio),
    .i_atn_n(atn_n), .i_ifc_n(ifc_n), .i_ren_n(ren_n), .i_eoi_n(w_eoi), .i_dav_n(w_dav),
    .i_nrfd_n(w_nrfd), .i_ndac_n(w_ndac), .o_dio_n(dio_n), .o_dio_oe(dio_oe),
    .o_eoi_n(eoi_n), .o_eoi_oe(eoi_oe), .o_dav_n(dav_n), .o_dav_oe(dav_oe),
    .o_nrfd_n(nrfd_n), .o_nrfd_oe(nrfd_oe), .o_ndac_n(ndac_n), .o_ndac_oe(ndac_oe),
    .o_srq_n(srq_n), .o_srq_oe(srq_oe), .o_rx_data(rx_data), .o_rx_end(rx_end),
    .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .i_tx_data(tx_data), .i_tx_end(tx_end),
    .i_tx_valid(tx_valid), .o_tx_take(tx_take), .i_srq_req(srq_req), .i_stb(stb),
    .o_listener(listener), .o_talker(talker), .o_remote(remote), .o_panel_lock(panel_lock),
    .o_spoll(spoll), .o_dev_clear(dev_clear), .o_trigger(trigger));
  gp_ctl_model u_gp_ctl_model (.i_core_clk(clk), .i_dio_w(w_dio), .i_eoi_w(w_eoi),
    .i_dav_w(w_dav), .i_nrfd_w(w_nrfd), .i_ndac_w(w_ndac), .o_dio_n(c_dio), .o_eoi_n(c_eoi),
    .o_dav_n(c_dav), .o_nrfd_n(c_nrfd), .o_ndac_n(c_ndac), .o_atn_n(atn_n), .o_ifc_n(ifc_n),
    .o_ren_n(ren_n));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd_b(input logic [7:0] v);
    u_gp_ctl_model.send(v, 1'b1, 1'b0);
    @(negedge clk);
  endtask
  task automatic results;
    n_fail += u_gp_ctl_model.n_to;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Parser readiness, receive watch, pulse counts and response feed, off the sampling edge.
  always @(negedge clk) begin
    rx_ready = stall ? 1'b0 : 1'($urandom);
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      check({7'h0, rx_end, rx_data}, (q.size() != 0) ? {7'h0, q.pop_front()} : 16'hffff);
    if (trigger === 1'b1) n_trig++;
    if (dev_clear === 1'b1) n_clr++;
    if (tx_take === 1'b1) void'(txq.pop_front());
    tx_valid = txq.size() != 0;
    {tx_end, tx_data} = (txq.size() != 0) ? txq[0] : 9'h000;
  end
  // Hang guard.
  initial begin
    #300000;
    n_fail++;
    results;
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h733a));
    a = 5'($urandom % 31);
    stb = 8'($urandom);
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    check({listener, talker, remote, srq_oe, dav_oe, nrfd_oe}, 16'h0000);
    u_gp_ctl_model.o_ren_n = 1'b0;
    cmd_b({1'b0, `GP_CMD_UNL});
    cmd_b({3'h1, a});
    check({listener, remote, talker}, 16'h0006);
    cmd_b({3'h3, 5'($urandom)});
    check({listener, talker}, 16'h0002);
    fork
      for (int k = 0; k < 3; k++) begin
        d = 8'($urandom);
        q.push_back({k == 2, d});
        u_gp_ctl_model.send(d, 1'b0, k == 2);
      end
    join_none
    repeat (100) @(negedge clk);
    check(w_nrfd, 16'h0000);
    stall = 1'b0;
    wait fork;
    repeat (40) @(negedge clk);
    check(q.size(), 16'h0000);
    for (i = 0; i < 5; i++) begin
      cmd_b({1'b0, cmd[i]});
      check({n_trig, n_clr, panel_lock, remote}, cex[i]);
    end
    cmd_b({1'b0, `GP_CMD_UNL});
    check(listener, 16'h0000);
    u_gp_ctl_model.send(8'h55, 1'b0, 1'b1);
    cmd_b({3'h2, a});
    check(talker, 16'h0001);
    u_gp_ctl_model.slow = 6;
    for (i = 0; i < 2; i++) begin
      txq.push_back({i == 1, 8'($urandom)});
      exq.push_back(txq[i]);
    end
    for (i = 0; i < 2; i++) begin
      u_gp_ctl_model.recv(b, e);
      check({e, b}, exq[i]);
    end
    repeat (6) @(negedge clk);
    check(txq.size(), 16'h0000);
    cmd_b({3'h2, 5'((a + 5'h01) % 31)});
    check(talker, 16'h0000);
    srq_req = 1'b1;
    @(negedge clk);
    srq_req = 1'b0;
    @(negedge clk);
    check(w_srq, 16'h0000);
    cmd_b({1'b0, `GP_CMD_SPE});
    cmd_b({3'h2, a});
    u_gp_ctl_model.recv(b, e);
    check(b, {stb[7], 1'b1, stb[5:0]});
    repeat (6) @(negedge clk);
    check(srq_oe, 16'h0000);
    cmd_b({1'b0, `GP_CMD_SPD});
    cmd_b({1'b0, `GP_CMD_UNT});
    check({spoll, talker}, 16'h0000);
    cmd_b({3'h1, a});
    cmd_b({3'h2, a});
    check({listener, talker}, 16'h0003);
    u_gp_ctl_model.o_ifc_n = 1'b0;
    repeat (4) @(negedge clk);
    u_gp_ctl_model.o_ifc_n = 1'b1;
    check({listener, talker}, 16'h0000);
    results;
  end
endmodule // test_gp_port
